// >>> rtl/lcd_instruction_decoder.sv
// Instruction decoder and control-register set of the LCD controller
`timescale 1ns/1ps
`default_nettype none
module lcd_instruction_decoder (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_xfer_valid,
  input wire logic i_instr_or_data_sel,
  input wire logic [7:0] i_code,
  input wire logic [6:0] i_disp_rd_addr,
  input wire logic [3:0] i_font_rd_addr,
  output lcd_decoder_pkg::settings_t o_settings,
  output logic [6:0] o_address_counter,
  output logic o_ram_select,
  output logic o_busy_flag,
  output logic o_blink_sync,
  output logic o_drivers_grounded,
  output logic [7:0] o_disp_rd_data,
  output logic [7:0] o_font_rd_data
);

  // ------------------------------------------------------------
  // State carrier
  // ------------------------------------------------------------
  typedef struct packed {
    lcd_decoder_pkg::phase_t phase;     // Idle or clearing
    logic [6:0] clr_cnt;                // Clear cycle count
    lcd_decoder_pkg::settings_t set;    // Stored settings
    logic [6:0] addr;                   // Address counter
    logic ram_select;                   // 0 display, 1 font
    logic busy;                         // Busy flag
    logic blink_sync;                   // Blink restart pulse
    logic grounded;                     // Drivers held at ground
  } state_t;

  state_t state_q;                      // Registered state
  state_t state_d;                      // Next state
  lcd_decoder_pkg::xfer_t xfer;         // Incoming transfer

  // Write strobes towards the RAMs, plus the transfer accept
  logic disp_we;
  logic font_we;
  logic fill;
  logic accept;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Counter step; wraps at either end of the 7-bit range
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic inc);
    step_addr = inc ? 7'(a + 7'h01) : 7'(a - 7'h01);
  endfunction : step_addr

  // True while RAM cannot be reached
  function automatic logic ram_locked(input lcd_decoder_pkg::settings_t s);
    ram_locked = s.sleep_request | s.standby_request;
  endfunction : ram_locked

  // Reset image of the whole state
  function automatic state_t reset_state();
    state_t r;
    r = '0;
    r.phase = lcd_decoder_pkg::PH_CLEAR;
    r.busy = 1'b1;
    r.grounded = 1'b1;
    r.addr = lcd_decoder_pkg::RST_ADDR;
    r.set.contrast_level = lcd_decoder_pkg::RST_CONTRAST;
    r.set.bias_select = lcd_decoder_pkg::RST_BIAS;
    r.set.addr_increment = lcd_decoder_pkg::RST_INCREMENT;
    r.set.duty_field = lcd_decoder_pkg::RST_DUTY;
    r.set.osc_started = lcd_decoder_pkg::RST_OSC;
    return r;
  endfunction : reset_state

  always_comb
  begin
    xfer.valid = i_xfer_valid;
    xfer.instr_or_data_sel = i_instr_or_data_sel;
    xfer.code = i_code;
  end

  // ------------------------------------------------------------
  // Decoder
  // ------------------------------------------------------------
  // Transfers are taken only when not busy; while busy they vanish
  always_comb
  begin
    state_d = state_q;
    state_d.blink_sync = 1'b0;
    disp_we = 1'b0;
    font_we = 1'b0;
    fill = 1'b0;
    accept = xfer.valid & ~state_q.busy;
    case (state_q.phase)
      lcd_decoder_pkg::PH_CLEAR:
      begin
        // Count out the clear, then release busy
        if (state_q.clr_cnt == lcd_decoder_pkg::CLEAR_LAST)
        begin
          state_d.phase = lcd_decoder_pkg::PH_IDLE;
          state_d.busy = 1'b0;
          state_d.clr_cnt = 7'h00;
        end
        else
        begin
          state_d.clr_cnt = 7'(state_q.clr_cnt + 7'h01);
        end
      end
      lcd_decoder_pkg::PH_IDLE:
      begin
        if (accept && xfer.instr_or_data_sel)
        begin
          // Data byte into the selected RAM, unless powered down
          if (!ram_locked(state_q.set))
          begin
            disp_we = ~state_q.ram_select;
            font_we = state_q.ram_select;
            state_d.addr = step_addr(state_q.addr, state_q.set.addr_increment);
          end
        end
        else if (accept)
        begin
          casez (xfer.code)
            lcd_decoder_pkg::CODE_NOP:
            begin
              // Nothing changes
              state_d = state_q;
              state_d.blink_sync = 1'b0;
            end
            lcd_decoder_pkg::CODE_CLEAR:
            begin
              // Space fill, counter home, busy for the clear
              fill = 1'b1;
              state_d.addr = 7'h00;
              state_d.ram_select = 1'b0;
              state_d.phase = lcd_decoder_pkg::PH_CLEAR;
              state_d.busy = 1'b1;
              state_d.clr_cnt = 7'h00;
            end
            lcd_decoder_pkg::CODE_HOME:
            begin
              state_d.addr = 7'h00;
              state_d.ram_select = 1'b0;
            end
            lcd_decoder_pkg::CODE_OSC:
            begin
              state_d.set.osc_started = 1'b1;
            end
            8'b0000_01??:
            begin
              state_d.set.common_scan_dir = xfer.code[1];
              state_d.set.segment_scan_dir = xfer.code[0];
            end
            8'b0000_1???:
            begin
              state_d.set.drive_supply_enable = xfer.code[2];
              state_d.set.sleep_request = xfer.code[1];
              state_d.set.standby_request = xfer.code[0];
            end
            8'b0001_0???:
            begin
              state_d.set.contrast_page_select = xfer.code[2];
              state_d.set.contrast_level[4:3] = xfer.code[1:0];
            end
            8'b0001_1???:
            begin
              // Page select steers this code to contrast or supply
              if (state_q.set.contrast_page_select)
              begin
                state_d.set.boost_factor = xfer.code[2];
                state_d.set.bias_select = xfer.code[1:0];
              end
              else
              begin
                state_d.set.contrast_level[2:0] = xfer.code[2:0];
              end
            end
            8'b0010_0???:
            begin
              state_d.set.font_bank = xfer.code[2];
              state_d.set.addr_increment = xfer.code[1];
              state_d.set.segment_blink_enable = xfer.code[0];
            end
            8'b0010_1???:
            begin
              state_d.set.invert_cursor = xfer.code[2];
              state_d.set.underline_cursor = xfer.code[1];
              state_d.set.blink_cursor = xfer.code[0];
            end
            8'b0011_0???:
            begin
              state_d.set.display_on = xfer.code[2];
              state_d.set.blink_period_select = xfer.code[1];
              state_d.set.line_cursor_enable = xfer.code[0];
            end
            8'b0011_1???:
            begin
              // Prohibited 011 is stored as given; the host avoids it
              state_d.set.duty_field = xfer.code[2:0];
            end
            8'b0100_000?:
            begin
              state_d.set.double_height_enable = xfer.code[0];
            end
            lcd_decoder_pkg::CODE_SYNC:
            begin
              state_d.blink_sync = 1'b1;
            end
            8'b10?0_000?:
            begin
              // Address loads are dropped while RAM is unreachable
              if (!ram_locked(state_q.set))
              begin
                state_d.ram_select = xfer.code[5];
                state_d.addr[6] = xfer.code[0];
              end
            end
            8'b11??_????:
            begin
              if (!ram_locked(state_q.set))
              begin
                state_d.addr[5:0] = xfer.code[5:0];
              end
            end
            default:
            begin
              // Unknown codes leave everything alone
              state_d = state_q;
              state_d.blink_sync = 1'b0;
            end
          endcase
        end
      end
      default:
      begin
        state_d.phase = lcd_decoder_pkg::PH_IDLE;
        state_d.busy = 1'b0;
      end
    endcase
    state_d.grounded = ~state_d.set.display_on;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Reset loads the documented image and starts the clear
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q <= reset_state();
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // RAMs
  // ------------------------------------------------------------
  // Display lines sit at 00-13, 20-33, 40-53, 60-73; font at 0-F
  lcd_ram_store #(
    .AW(lcd_decoder_pkg::DISP_AW),
    .DEPTH(lcd_decoder_pkg::DISP_DEPTH)
  ) u_display_ram (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_wr_en(disp_we),
    .i_wr_addr(state_q.addr),
    .i_wr_data(xfer.code),
    .i_fill(fill),
    .i_rd_addr(i_disp_rd_addr),
    .o_rd_data(o_disp_rd_data)
  );

  lcd_ram_store #(
    .AW(lcd_decoder_pkg::FONT_AW),
    .DEPTH(lcd_decoder_pkg::FONT_DEPTH)
  ) u_font_ram (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_wr_en(font_we),
    .i_wr_addr(state_q.addr[3:0]),
    .i_wr_data(xfer.code),
    .i_fill(1'b0),
    .i_rd_addr(i_font_rd_addr),
    .o_rd_data(o_font_rd_data)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_settings = state_q.set;
  assign o_address_counter = state_q.addr;
  assign o_ram_select = state_q.ram_select;
  assign o_busy_flag = state_q.busy;
  assign o_blink_sync = state_q.blink_sync;
  assign o_drivers_grounded = state_q.grounded;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic instr_acc;
  logic data_acc;
  assign instr_acc = xfer.valid & ~o_busy_flag & ~xfer.instr_or_data_sel;
  assign data_acc = xfer.valid & ~o_busy_flag & xfer.instr_or_data_sel;

  sequence seq_clear_run;
    o_busy_flag [*8];
  endsequence

  sequence seq_clear_end;
    ##77 o_busy_flag ##1 !o_busy_flag;
  endsequence

  AST_CLEAR_LEN: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (instr_acc && xfer.code == lcd_decoder_pkg::CODE_CLEAR) |=> seq_clear_run ##0 seq_clear_end)
    else $error("clear did not take 85 busy cycles");

  AST_CLEAR_ADDR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (instr_acc && xfer.code == lcd_decoder_pkg::CODE_CLEAR) |=> (o_address_counter == 7'h00 && !o_ram_select))
    else $error("clear did not zero the counter");

  AST_NOP_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (instr_acc && xfer.code == lcd_decoder_pkg::CODE_NOP) |=> ($stable(o_settings) && $stable(o_address_counter)))
    else $error("no-operation changed state");

  AST_BUSY_IGNORE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_busy_flag && xfer.valid) |=> ($stable(o_settings) && $stable(o_address_counter)))
    else $error("transfer taken while busy");

  AST_DATA_STEP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (data_acc && !o_settings.sleep_request && !o_settings.standby_request) |=>
    (o_address_counter == step_addr($past(o_address_counter), $past(o_settings.addr_increment))))
    else $error("counter did not step after a write");

  AST_SCAN_DIR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (instr_acc && xfer.code[7:2] == 6'b000001) |=>
    (o_settings.common_scan_dir == $past(xfer.code[1]) && o_settings.segment_scan_dir == $past(xfer.code[0])))
    else $error("scan directions not stored");

  AST_DUTY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (instr_acc && xfer.code[7:3] == 5'b00111) |=> (o_settings.duty_field == $past(xfer.code[2:0])))
    else $error("duty field not stored");

  AST_BIAS_PAGE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (instr_acc && xfer.code[7:3] == 5'b00011 && !o_settings.contrast_page_select) |=> $stable(o_settings.bias_select))
    else $error("bias changed on the contrast page");

  AST_SYNC_PULSE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (instr_acc && xfer.code == lcd_decoder_pkg::CODE_SYNC) |=> o_blink_sync ##1 !o_blink_sync)
    else $error("blink restart not a single pulse");

  AST_GROUND: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_drivers_grounded == !o_settings.display_on)
    else $error("drivers not grounded with display off");

  AST_RESET_CLEAR: assert property (@(posedge i_clk)
    $rose(i_rstn) |-> (o_busy_flag && o_settings.duty_field == lcd_decoder_pkg::RST_DUTY
    && o_settings.addr_increment && o_address_counter == 7'h00))
    else $error("reset image wrong");

endmodule : lcd_instruction_decoder
`default_nettype wire

// >>> rtl/lcd_decoder_pkg.sv
// Shared constants and carriers for the LCD instruction decoder
package lcd_decoder_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int DISP_AW = 7;          // Display RAM address width
  localparam int DISP_DEPTH = 128;     // Display RAM words
  localparam int FONT_AW = 4;          // Font RAM address width
  localparam int FONT_DEPTH = 16;      // Font RAM words
  localparam int DATA_W = 8;           // RAM word width

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLEAR_CYCLES = 85;    // Clear-display length in operating clocks
  localparam logic [6:0] CLEAR_LAST = 7'(CLEAR_CYCLES - 1);

  // ------------------------------------------------------------
  // Codes and fill value
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_NOP = 8'h00;
  localparam logic [7:0] CODE_CLEAR = 8'h01;
  localparam logic [7:0] CODE_HOME = 8'h02;
  localparam logic [7:0] CODE_OSC = 8'h03;
  localparam logic [7:0] CODE_SYNC = 8'h70;
  localparam logic [7:0] SPACE_CODE = 8'h20;

  // ------------------------------------------------------------
  // Reset values of fields
  // ------------------------------------------------------------
  localparam logic [4:0] RST_CONTRAST = 5'h00;
  localparam logic [1:0] RST_BIAS = 2'h0;
  localparam logic [2:0] RST_DUTY = 3'h5;
  localparam logic RST_INCREMENT = 1'b1;
  localparam logic RST_OSC = 1'b1;
  localparam logic [6:0] RST_ADDR = 7'h00;

  // Decoder phases
  typedef enum logic [0:0] {PH_IDLE, PH_CLEAR} phase_t;

  // All stored control settings
  typedef struct packed {
    logic common_scan_dir;
    logic segment_scan_dir;
    logic drive_supply_enable;
    logic sleep_request;
    logic standby_request;
    logic contrast_page_select;
    logic [4:0] contrast_level;
    logic boost_factor;
    logic [1:0] bias_select;
    logic font_bank;
    logic addr_increment;
    logic segment_blink_enable;
    logic invert_cursor;
    logic underline_cursor;
    logic blink_cursor;
    logic display_on;
    logic blink_period_select;
    logic line_cursor_enable;
    logic [2:0] duty_field;
    logic double_height_enable;
    logic osc_started;
  } settings_t;

  // Incoming transfer from the transport layer
  typedef struct packed {
    logic valid;
    logic instr_or_data_sel;
    logic [7:0] code;
  } xfer_t;

endpackage : lcd_decoder_pkg

// >>> rtl/lcd_ram_store.sv
// Small RAM with registered read and optional whole-array fill
`timescale 1ns/1ps
`default_nettype none
module lcd_ram_store #(
  parameter int AW = 4,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_fill,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] mem [DEPTH];            // Word array, no reset
  logic [DEPTH-1:0] blank_q;          // Word reads as space code
  logic [7:0] rd_q;                   // Registered read data

  // Array writes; a fill marks every word blank in one clock,
  // which is how the clear finishes well inside its cycle budget
  always_ff @(posedge i_clk)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Blank flags start set so reset itself clears the display
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      blank_q <= '1;
      rd_q <= 8'h00;
    end
    else
    begin
      if (i_fill)
      begin
        blank_q <= '1;
      end
      else if (i_wr_en)
      begin
        blank_q[i_wr_addr] <= 1'b0;
      end
      rd_q <= blank_q[i_rd_addr] ? lcd_decoder_pkg::SPACE_CODE : mem[i_rd_addr];
    end
  end

  assign o_rd_data = rd_q;

endmodule : lcd_ram_store
`default_nettype wire

// >>> verif/lcd_host_model.sv
// Host model that hands instruction and data bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
  input wire logic i_clk,
  input wire logic i_busy_flag,
  output logic o_xfer_valid,
  output logic o_instr_or_data_sel,
  output logic [7:0] o_code
);
  // ---------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------
  initial
  begin
    o_xfer_valid = 1'b0;
    o_instr_or_data_sel = 1'b0;
    o_code = 8'h00;
  end

  // ---------------------------------------------------------
  // One transfer; hold keeps valid up for a back-to-back follow-up
  // ---------------------------------------------------------
  task automatic send(input logic sel, input logic [7:0] code, input bit hold, input bit wait_rdy);
    int n;
    n = 0;
    // Ready wait is bounded so a stuck busy flag cannot hang the run
    while (wait_rdy && i_busy_flag !== 1'b0 && n < 1000)
    begin
      @(posedge i_clk);
      #2;
      n++;
    end
    o_xfer_valid = 1'b1;
    o_instr_or_data_sel = sel;
    o_code = code;
    @(posedge i_clk);
    #2;
    if (!hold)
    begin
      // Released bus shows inverted payload, never the stale byte
      o_xfer_valid = 1'b0;
      o_instr_or_data_sel = ~sel;
      o_code = ~code;
      // One idle edge so valid is never lowered and raised in one step
      @(posedge i_clk);
      #2;
    end
  endtask : send
endmodule : lcd_host_model
`default_nettype wire

// >>> verif/lcd_instruction_decoder_tb.sv
// Self-checking testbench for the LCD instruction decoder
`timescale 1ns/1ps
`default_nettype none
module lcd_instruction_decoder_tb;
  // ---------------------------------------------------------
  // Clock, reset and wiring
  // ---------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic xfer_valid;
  logic xfer_sel;
  logic [7:0] xfer_code;
  logic [6:0] disp_rd_addr = 7'h00;
  logic [3:0] font_rd_addr = 4'h0;
  lcd_decoder_pkg::settings_t settings;
  lcd_decoder_pkg::settings_t exp; // Expected settings image
  logic [6:0] addr_cnt;
  logic ram_sel, busy, blink_sync, grounded;
  logic [7:0] disp_rd_data, font_rd_data;
  int num_errors = 0;
  int total_checks = 0;

  // 40 MHz operating clock
  always #12.5 i_clk = ~i_clk;

  lcd_instruction_decoder u_lcd_instruction_decoder (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_xfer_valid(xfer_valid),
    .i_instr_or_data_sel(xfer_sel), .i_code(xfer_code),
    .i_disp_rd_addr(disp_rd_addr), .i_font_rd_addr(font_rd_addr),
    .o_settings(settings), .o_address_counter(addr_cnt), .o_ram_select(ram_sel),
    .o_busy_flag(busy), .o_blink_sync(blink_sync), .o_drivers_grounded(grounded),
    .o_disp_rd_data(disp_rd_data), .o_font_rd_data(font_rd_data)
  );

  lcd_host_model u_host (
    .i_clk(i_clk), .i_busy_flag(busy), .o_xfer_valid(xfer_valid),
    .o_instr_or_data_sel(xfer_sel), .o_code(xfer_code)
  );

  // ---------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
    total_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[FAIL] %0t %s: got %0h want %0h", $time, what, seen, want);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask : tick

  task automatic tx(input logic sel, input logic [7:0] c, input bit hold = 0, input bit wr = 1);
    u_host.send(sel, c, hold, wr);
  endtask : tx

  task automatic cs();
    chk(32'(settings), 32'(exp), "settings");
  endtask : cs

  // Registered read, one cycle after the address
  task automatic rd(input bit font, input logic [6:0] a, input logic [7:0] d);
    disp_rd_addr = a;
    font_rd_addr = a[3:0];
    tick(1);
    chk(font ? font_rd_data : disp_rd_data, 32'(d), "ram read");
  endtask : rd

  // ---------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------
  task automatic t_reset();
    exp = '0;
    exp.duty_field = 3'h5;
    exp.addr_increment = 1'b1;
    exp.osc_started = 1'b1;
    tick(4);
    chk(busy, 1, "busy in reset");
    cs();
    chk(addr_cnt, 0, "counter");
    chk(grounded, 1, "grounded");
    i_rstn = 1'b1;
    tick(80);
    chk(busy, 1, "busy after release");
    tick(420);
    chk(busy, 0, "busy end");
    rd(0, 7'h33, 8'h20);
    $display("test reset done");
  endtask : t_reset

  task automatic t_fields();
    for (int v = 0; v < 8; v++)
    begin
      tx(0, 8'h04 | 8'(v[1:0]));
      {exp.common_scan_dir, exp.segment_scan_dir} = v[1:0];
      cs();
      tx(0, 8'h08 | 8'(v));
      {exp.drive_supply_enable, exp.sleep_request, exp.standby_request} = v[2:0];
      cs();
      tx(0, 8'h20 | 8'(v));
      {exp.font_bank, exp.addr_increment, exp.segment_blink_enable} = v[2:0];
      cs();
      tx(0, 8'h28 | 8'(v));
      {exp.invert_cursor, exp.underline_cursor, exp.blink_cursor} = v[2:0];
      cs();
      tx(0, 8'h30 | 8'(v));
      {exp.display_on, exp.blink_period_select, exp.line_cursor_enable} = v[2:0];
      cs();
      chk(grounded, 32'(!v[2]), "grounded");
      // Prohibited duty code is never sent
      if (v != 3 && v != 7)
      begin
        tx(0, 8'h38 | 8'(v));
        exp.duty_field = v[2:0];
        cs();
      end
      tx(0, 8'h40 | 8'(v[0]));
      exp.double_height_enable = v[0];
      cs();
    end
    $display("test fields done");
  endtask : t_fields

  task automatic t_contrast();
    tx(0, 8'h12);
    exp.contrast_page_select = 1'b0;
    exp.contrast_level[4:3] = 2'b10;
    cs();
    tx(0, 8'h1D);
    exp.contrast_level[2:0] = 3'b101;
    cs();
    // Upper bits resent unchanged, only the page flips
    tx(0, 8'h16);
    exp.contrast_page_select = 1'b1;
    cs();
    tx(0, 8'h1B);
    exp.boost_factor = 1'b0;
    exp.bias_select = 2'b11;
    cs();
    tx(0, 8'h1D);
    exp.boost_factor = 1'b1;
    exp.bias_select = 2'b01;
    cs();
    tx(0, 8'h12);
    exp.contrast_page_select = 1'b0;
    cs();
    $display("test contrast done");
  endtask : t_contrast

  task automatic t_ram();
    // Power-save off before any RAM traffic
    tx(0, 8'h08);
    tx(0, 8'h22);
    {exp.drive_supply_enable, exp.sleep_request, exp.standby_request} = 3'b000;
    {exp.font_bank, exp.addr_increment, exp.segment_blink_enable} = 3'b010;
    tx(0, 8'h81);
    tx(0, 8'hF3);
    chk(addr_cnt, 7'h73, "line four");
    tx(1, 8'hA5, 1);
    tx(1, 8'h3C);
    chk(addr_cnt, 7'h75, "increment");
    rd(0, 7'h73, 8'hA5);
    rd(0, 7'h74, 8'h3C);
    tx(0, 8'h20);
    tx(0, 8'h80);
    tx(0, 8'hC0);
    tx(1, 8'h11);
    chk(addr_cnt, 7'h7F, "decrement");
    rd(0, 7'h00, 8'h11);
    tx(0, 8'h22);
    tx(0, 8'hA0);
    tx(0, 8'hC8);
    chk(ram_sel, 1, "font select");
    tx(1, 8'h5A);
    rd(1, 7'h08, 8'h5A);
    rd(0, 7'h08, 8'h20);
    cs();
    $display("test ram done");
  endtask : t_ram

  task automatic t_clear();
    int n;
    tx(0, 8'h01, 1);
    // Offered while busy, must be dropped
    tx(0, 8'h30, 0, 0);
    n = 2;
    while (busy === 1'b1 && n < 200)
    begin
      n++;
      tick(1);
    end
    chk(n, 85, "clear length");
    chk(addr_cnt, 0, "clear counter");
    chk(ram_sel, 0, "clear select");
    cs();
    tx(1, 8'h41);
    rd(0, 7'h00, 8'h41);
    rd(0, 7'h73, 8'h20);
    $display("test clear done");
  endtask : t_clear

  task automatic t_misc();
    logic [7:0] undef [6] = '{8'h42, 8'h50, 8'h6F, 8'h71, 8'h90, 8'hB1};
    tx(0, 8'h80);
    tx(0, 8'hC5);
    tx(0, 8'h00);
    cs();
    chk(busy, 0, "nop busy");
    foreach (undef[i])
    begin
      tx(0, undef[i]);
      cs();
      chk(addr_cnt, 7'h05, "undefined");
    end
    tx(0, 8'h03);
    cs();
    tx(0, 8'h02);
    chk(addr_cnt, 0, "home");
    tx(0, 8'h70, 1);
    chk(blink_sync, 1, "sync pulse");
    tx(0, 8'h00);
    chk(blink_sync, 0, "sync end");
    $display("test misc done");
  endtask : t_misc

  // ---------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ---------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  initial
  begin
    t_reset();
    t_fields();
    t_contrast();
    t_ram();
    t_clear();
    t_misc();
    final_report();
  end

  // Whole run is about 770 cycles
  initial
  begin
    #(25 * 6000);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule : lcd_instruction_decoder_tb
`default_nettype wire
